/* shared/spp_cfg.svh */
// Constants for the status, page and first-PWM register slice
// How it works
// - Power-down flag set at power-on or watchdog clear, cleared by sleep.
// - Time-out flag set by sleep, watchdog clear or power-up; cleared on expiry.
// - Flags give 00 watchdog wake, 01 expiry awake, 10 reset wake, 11 power-up.
// - Status bit 5 picks control-register page 0 or 1.
// - Status bits 7:6 pick one of four special-register pages.
// - Carry, half-carry and zero flags sit in status bits 0 to 2, read-write.
// - Low six bits of RAM select act as the indirect pointer.
// - RAM select bits 7:6 choose one of four banks; reset to zero.
// - Program page bits 1:0 select program page 0 to 3; reset zero.
// - Timebase one prescaler divides by 2, 8, 32 or 64; default 2.
// - Timebase two prescaler uses the same ratios; default 2.
// - Control bits 4 and 5 run timebase one and two; off at reset.
// - Control bit 6 gives port C pin one to PWM one, forced output.
// - Control bit 7 gives port C pin two to PWM two, forced output.
// - First duty is ten bits: low byte plus high register bits 1:0.
// - PWM one high from period start until counter equals duty.
// - Duty-high bits 7:2 always read zero.
// - ADC resolution bit picks 8-bit latching or extra top bits 5:4.
// - Port 7 bit 1 is read-only; option makes pin input or reset.
// - Port 6 bits 1:0 are GPIO in RC modes, crystal pins otherwise.
// - Register address zero accesses the location the pointer holds.
// - Jumps load program counter bits 11:10 from program page bits.
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH

`define SPP_ADDR_INDIRECT   6'h00
`define SPP_ADDR_STATUS     6'h03
`define SPP_ADDR_RAM_SEL    6'h04
`define SPP_ADDR_PROG_PWM   6'h05
`define SPP_ADDR_PORT6_DUTY 6'h06
`define SPP_ADDR_PORT7_MIX  6'h07

`define SPP_PAGE0           2'h0
`define SPP_PAGE1           2'h1
`define SPP_PAGE3           2'h3

`define SPP_STATUS_RESET    8'h18
`define SPP_STATUS_SW_MASK  8'hE7
`define SPP_RAM_SEL_RESET   8'h00
`define SPP_PWM_CTL_RESET   8'h00
`define SPP_PROG_PAGE_MASK  8'h0F
`define SPP_PORT6_MASK      8'h3F
`define SPP_PORT7_MASK      8'h79
`define SPP_DUTY_HI_MASK    8'h03

`define SPP_BIT_PD          3
`define SPP_BIT_TO          4
`define SPP_BIT_ADC_RES     2

`define SPP_DIV2_LIMIT      6'h01
`define SPP_DIV8_LIMIT      6'h07
`define SPP_DIV32_LIMIT     6'h1F
`define SPP_DIV64_LIMIT     6'h3F

`endif

/* shared/spp_pkg.sv */
// Types for the status, page and first-PWM register slice
package spp_pkg;

    typedef struct packed {
        logic [5:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } spp_cpu_req_t;

    typedef struct packed {
        logic p71_pin;
        logic crystal_mode;
        logic reset_pin_option;
        logic pll_cap_pin_option;
    } spp_pin_in_t;

    typedef struct packed {
        logic data;
        logic oe_n;
    } spp_pin_drv_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] ram_sel;
        logic [3:0] prog_page;
        logic [7:0] pwm_ctl;
        logic [5:0] port6;
        logic [7:0] port7;
        logic [9:0] duty;
        logic       adc_res;
        logic [1:0] adc_top;
        logic [7:0] adc_low;
        logic [5:0] pre1;
        logic [5:0] pre2;
        logic [9:0] count1;
        logic [9:0] count2;
        logic       pwm1_lvl;
        logic [1:0] pc_hi;
        logic [7:0] rdata;
        spp_pin_in_t sync1;
        spp_pin_in_t sync2;
    } spp_state_t;

endpackage

/* src/spp_regs.sv */
// Status, page select, RAM pointer, first PWM and port data registers
`timescale 1ns/1ps
`default_nettype none
`include "spp_cfg.svh"

module spp_regs (
    // Clock and reset
    input  wire logic                 mclk_in,
    input  wire logic                 resetn_in,
    // CPU register access
    input  wire spp_pkg::spp_cpu_req_t cpu_req_in,
    output logic [7:0]                reg_rdata_out,
    output logic [5:0]                eff_addr_out,
    output logic                      indirect_out,
    output logic [1:0]                ram_bank_out,
    output logic [1:0]                reg_page_out,
    output logic                      ctrl_page_out,
    // Core events
    input  wire logic                 sleep_instr_in,
    input  wire logic                 watchdog_clear_instr_in,
    input  wire logic                 wdt_expire_in,
    input  wire logic                 pc_page_load_in,
    output logic [1:0]                prog_page_out,
    output logic [1:0]                pc_high_out,
    // ADC result
    input  wire logic                 adc_done_in,
    input  wire logic [9:0]           adc_result_in,
    output logic [7:0]                adc_low_out,
    // PWM
    input  wire logic                 pwm_two_wave_in,
    output logic [9:0]                first_counter_out,
    output logic [9:0]                second_counter_out,
    output logic                      pwm_one_wave_out,
    // Port C pins one and two
    input  wire spp_pkg::spp_pin_drv_t port_c_one_in,
    input  wire spp_pkg::spp_pin_drv_t port_c_two_in,
    output spp_pkg::spp_pin_drv_t     port_c_pin_one_out,
    output spp_pkg::spp_pin_drv_t     port_c_pin_two_out,
    // Port 6 and 7
    input  wire spp_pkg::spp_pin_in_t pins_in,
    output logic [5:0]                port6_data_out,
    output logic [7:0]                port7_data_out,
    output logic [1:0]                port6_gpio_out,
    output logic                      p70_gpio_out
);
    import spp_pkg::*;

    spp_state_t st_r;
    spp_state_t st_nxt;

    logic [5:0] eff_addr;
    logic       local_hit;
    logic       wr_hit;
    logic [1:0] page;
    logic       tick1;
    logic       tick2;
    logic [9:0] count1_up;

    // Shared by both timebases
    function automatic logic [5:0] div_limit(input logic [1:0] code);
        unique case (code)
            2'h0: div_limit = `SPP_DIV2_LIMIT;
            2'h1: div_limit = `SPP_DIV8_LIMIT;
            2'h2: div_limit = `SPP_DIV32_LIMIT;
            2'h3: div_limit = `SPP_DIV64_LIMIT;
        endcase
    endfunction

    function automatic logic [7:0] read_reg(input spp_state_t s, input logic [5:0] a,
                                            input logic [1:0] pg, input logic p71_rd);
        read_reg = 8'h00;
        // Status and RAM select stay reachable from every page so software can leave a page
        if (a == `SPP_ADDR_STATUS) begin
            read_reg = s.status;
        end else if (a == `SPP_ADDR_RAM_SEL) begin
            read_reg = s.ram_sel;
        end else if (a == `SPP_ADDR_PROG_PWM && pg == `SPP_PAGE0) begin
            read_reg = {4'h0, s.prog_page};
        end else if (a == `SPP_ADDR_PROG_PWM && pg == `SPP_PAGE3) begin
            read_reg = s.pwm_ctl;
        end else if (a == `SPP_ADDR_PORT6_DUTY && pg == `SPP_PAGE0) begin
            read_reg = {2'h0, s.port6};
        end else if (a == `SPP_ADDR_PORT6_DUTY && pg == `SPP_PAGE3) begin
            read_reg = s.duty[7:0];
        end else if (a == `SPP_ADDR_PORT7_MIX && pg == `SPP_PAGE0) begin
            read_reg = (s.port7 & `SPP_PORT7_MASK) | {6'h00, p71_rd, 1'b0};
        end else if (a == `SPP_ADDR_PORT7_MIX && pg == `SPP_PAGE1) begin
            read_reg = {2'h0, s.adc_top, 1'b0, s.adc_res, 2'h0};
        end else if (a == `SPP_ADDR_PORT7_MIX && pg == `SPP_PAGE3) begin
            read_reg = {6'h00, s.duty[9:8]};
        end
    endfunction

    assign page      = st_r.status[7:6];
    assign eff_addr  = (cpu_req_in.addr == `SPP_ADDR_INDIRECT) ? st_r.ram_sel[5:0]
                                                               : cpu_req_in.addr;
    assign local_hit = (eff_addr[5:4] == 2'h0) && (eff_addr != `SPP_ADDR_INDIRECT);
    assign wr_hit    = cpu_req_in.wr && local_hit;
    assign tick1     = st_r.pwm_ctl[4] && (st_r.pre1 == div_limit(st_r.pwm_ctl[1:0]));
    assign tick2     = st_r.pwm_ctl[5] && (st_r.pre2 == div_limit(st_r.pwm_ctl[3:2]));
    assign count1_up = st_r.count1 + 10'h001;

    always_comb begin
        st_nxt = st_r;

        // Pin and strap synchroniser
        st_nxt.sync1 = pins_in;
        st_nxt.sync2 = st_r.sync1;

        // Software writes
        if (wr_hit) begin
            unique case (eff_addr)
                `SPP_ADDR_STATUS: begin
                    st_nxt.status = (cpu_req_in.wdata & `SPP_STATUS_SW_MASK)
                                  | (st_r.status & ~`SPP_STATUS_SW_MASK);
                end
                `SPP_ADDR_RAM_SEL: begin
                    st_nxt.ram_sel = cpu_req_in.wdata;
                end
                `SPP_ADDR_PROG_PWM: begin
                    if (page == `SPP_PAGE0) begin
                        st_nxt.prog_page = cpu_req_in.wdata[3:0];
                    end else if (page == `SPP_PAGE3) begin
                        st_nxt.pwm_ctl = cpu_req_in.wdata;
                    end
                end
                `SPP_ADDR_PORT6_DUTY: begin
                    if (page == `SPP_PAGE0) begin
                        st_nxt.port6 = cpu_req_in.wdata[5:0];
                    end else if (page == `SPP_PAGE3) begin
                        st_nxt.duty[7:0] = cpu_req_in.wdata;
                    end
                end
                `SPP_ADDR_PORT7_MIX: begin
                    if (page == `SPP_PAGE0) begin
                        st_nxt.port7 = cpu_req_in.wdata & `SPP_PORT7_MASK;
                    end else if (page == `SPP_PAGE1) begin
                        st_nxt.adc_res = cpu_req_in.wdata[`SPP_BIT_ADC_RES];
                    end else if (page == `SPP_PAGE3) begin
                        st_nxt.duty[9:8] = cpu_req_in.wdata[1:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // Power-down and time-out flags; set beats the expiry clear of time-out
        if (watchdog_clear_instr_in) begin
            st_nxt.status[`SPP_BIT_PD] = 1'b1;
        end else if (sleep_instr_in) begin
            st_nxt.status[`SPP_BIT_PD] = 1'b0;
        end
        if (sleep_instr_in || watchdog_clear_instr_in) begin
            st_nxt.status[`SPP_BIT_TO] = 1'b1;
        end else if (wdt_expire_in) begin
            st_nxt.status[`SPP_BIT_TO] = 1'b0;
        end

        // ADC latch
        if (adc_done_in) begin
            if (st_r.adc_res) begin
                st_nxt.adc_low = adc_result_in[7:0];
                st_nxt.adc_top = adc_result_in[9:8];
            end else begin
                st_nxt.adc_low = adc_result_in[9:2];
                st_nxt.adc_top = 2'h0;
            end
        end

        // Timebases hold while stopped
        if (st_r.pwm_ctl[4]) begin
            st_nxt.pre1 = tick1 ? 6'h00 : st_r.pre1 + 6'h01;
        end
        if (st_r.pwm_ctl[5]) begin
            st_nxt.pre2 = tick2 ? 6'h00 : st_r.pre2 + 6'h01;
        end
        if (tick1) begin
            st_nxt.count1 = count1_up;
            // Period starts at wrap to zero; a zero duty keeps the output low
            if (count1_up == 10'h000) begin
                st_nxt.pwm1_lvl = (st_r.duty != 10'h000);
            end else if (count1_up == st_r.duty) begin
                st_nxt.pwm1_lvl = 1'b0;
            end
        end
        if (tick2) begin
            st_nxt.count2 = st_r.count2 + 10'h001;
        end

        // Program counter high bits
        if (pc_page_load_in) begin
            st_nxt.pc_hi = st_r.prog_page[1:0];
        end

        // Registered read, one cycle after the address
        st_nxt.rdata = local_hit ? read_reg(st_r, eff_addr, page,
                                            st_r.sync2.p71_pin & ~st_r.sync2.reset_pin_option)
                                 : 8'h00;
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r         <= '0;
            st_r.status  <= `SPP_STATUS_RESET;
            st_r.ram_sel <= `SPP_RAM_SEL_RESET;
            st_r.pwm_ctl <= `SPP_PWM_CTL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out      = st_r.rdata;
    assign eff_addr_out       = eff_addr;
    assign indirect_out       = (cpu_req_in.addr == `SPP_ADDR_INDIRECT);
    assign ram_bank_out       = st_r.ram_sel[7:6];
    assign reg_page_out       = page;
    assign ctrl_page_out      = st_r.status[5];
    assign prog_page_out      = st_r.prog_page[1:0];
    assign pc_high_out        = st_r.pc_hi;
    assign adc_low_out        = st_r.adc_low;
    assign first_counter_out  = st_r.count1;
    assign second_counter_out = st_r.count2;
    assign pwm_one_wave_out   = st_r.pwm1_lvl;
    assign port6_data_out     = st_r.port6;
    assign port7_data_out     = st_r.port7;
    assign port6_gpio_out     = {2{~st_r.sync2.crystal_mode}};
    // PLL must stay off when this is high in crystal mode
    assign p70_gpio_out       = ~st_r.sync2.crystal_mode | st_r.sync2.pll_cap_pin_option;

    always_comb begin
        if (st_r.pwm_ctl[6]) begin
            port_c_pin_one_out = '{data: st_r.pwm1_lvl, oe_n: 1'b0};
        end else begin
            port_c_pin_one_out = port_c_one_in;
        end
        if (st_r.pwm_ctl[7]) begin
            port_c_pin_two_out = '{data: pwm_two_wave_in, oe_n: 1'b0};
        end else begin
            port_c_pin_two_out = port_c_two_in;
        end
    end

    property p_sleep_flags;
        @(posedge mclk_in) disable iff (!resetn_in)
        sleep_instr_in && !watchdog_clear_instr_in |=>
            !st_r.status[`SPP_BIT_PD] && st_r.status[`SPP_BIT_TO];
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

    property p_watchdog_clear_instr_flags;
        @(posedge mclk_in) disable iff (!resetn_in)
        watchdog_clear_instr_in |=> st_r.status[`SPP_BIT_PD] && st_r.status[`SPP_BIT_TO];
    endproperty
    a_watchdog_clear_instr_flags: assert property (p_watchdog_clear_instr_flags) else $error("watchdog clear flags wrong");

    property p_expire_flags;
        @(posedge mclk_in) disable iff (!resetn_in)
        wdt_expire_in && !sleep_instr_in && !watchdog_clear_instr_in |=>
            !st_r.status[`SPP_BIT_TO] && $stable(st_r.status[`SPP_BIT_PD]);
    endproperty
    a_expire_flags: assert property (p_expire_flags) else $error("expiry flags wrong");

    property p_ro_flags;
        @(posedge mclk_in) disable iff (!resetn_in)
        wr_hit && eff_addr == `SPP_ADDR_STATUS && !sleep_instr_in && !watchdog_clear_instr_in
            && !wdt_expire_in |=> $stable(st_r.status[4:3]) && st_r.status[2:0] ==
            $past(cpu_req_in.wdata[2:0]);
    endproperty
    a_ro_flags: assert property (p_ro_flags) else $error("status write wrong");

    property p_duty_hi_read;
        @(posedge mclk_in) disable iff (!resetn_in)
        eff_addr == `SPP_ADDR_PORT7_MIX && page == `SPP_PAGE3 |=>
            reg_rdata_out == {6'h00, st_r.duty[9:8]} || $changed(st_r.duty);
    endproperty
    a_duty_hi_read: assert property (p_duty_hi_read) else $error("duty high read wrong");

    property p_pin_one;
        @(posedge mclk_in) disable iff (!resetn_in)
        st_r.pwm_ctl[6] |-> !port_c_pin_one_out.oe_n && port_c_pin_one_out.data == pwm_one_wave_out;
    endproperty
    a_pin_one: assert property (p_pin_one) else $error("PWM pin one not driven");

    property p_stopped;
        @(posedge mclk_in) disable iff (!resetn_in)
        !st_r.pwm_ctl[4] |=> st_r.count1 == $past(st_r.count1);
    endproperty
    a_stopped: assert property (p_stopped) else $error("timebase one ran while off");

    property p_prescale;
        @(posedge mclk_in) disable iff (!resetn_in)
        st_r.count1 != $past(st_r.count1) |->
            $past(st_r.pre1) == div_limit($past(st_r.pwm_ctl[1:0]));
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler ratio wrong");

    property p_indirect;
        @(posedge mclk_in) disable iff (!resetn_in)
        cpu_req_in.addr == `SPP_ADDR_INDIRECT |-> eff_addr_out == st_r.ram_sel[5:0];
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect address wrong");

    property p_pc_high;
        @(posedge mclk_in) disable iff (!resetn_in)
        pc_page_load_in |=> pc_high_out == $past(st_r.prog_page[1:0]);
    endproperty
    a_pc_high: assert property (p_pc_high) else $error("pc high bits wrong");

    property p_adc8;
        @(posedge mclk_in) disable iff (!resetn_in)
        adc_done_in && !st_r.adc_res |=>
            adc_low_out == $past(adc_result_in[9:2]) && st_r.adc_top == 2'h0;
    endproperty
    a_adc8: assert property (p_adc8) else $error("8-bit ADC latch wrong");

    property p_duty_end;
        @(posedge mclk_in) disable iff (!resetn_in)
        tick1 && count1_up == st_r.duty && count1_up != 10'h000 |=> !pwm_one_wave_out;
    endproperty
    a_duty_end: assert property (p_duty_end) else $error("PWM one not low at duty");

    // Wrap starts a period; only a zero duty keeps the level low
    property p_wrap_high;
        @(posedge mclk_in) disable iff (!resetn_in)
        tick1 && count1_up == 10'h000 |=> pwm_one_wave_out == ($past(st_r.duty) != 10'h000);
    endproperty
    a_wrap_high: assert property (p_wrap_high) else $error("PWM one wrong at period start");

    property p_adc10;
        @(posedge mclk_in) disable iff (!resetn_in)
        adc_done_in && st_r.adc_res |=>
            adc_low_out == $past(adc_result_in[7:0])
            && st_r.adc_top == $past(adc_result_in[9:8]);
    endproperty
    a_adc10: assert property (p_adc10) else $error("10-bit ADC latch wrong");

    property p_pin_two;
        @(posedge mclk_in) disable iff (!resetn_in)
        st_r.pwm_ctl[7] |-> !port_c_pin_two_out.oe_n
            && port_c_pin_two_out.data == pwm_two_wave_in;
    endproperty
    a_pin_two: assert property (p_pin_two) else $error("PWM pin two not driven");

    c_sleep_then_expire: cover property (@(posedge mclk_in) disable iff (!resetn_in)
        sleep_instr_in ##[1:20] wdt_expire_in);
    c_pwm_rise: cover property (@(posedge mclk_in) disable iff (!resetn_in)
        $rose(pwm_one_wave_out));
    c_indirect_write: cover property (@(posedge mclk_in) disable iff (!resetn_in)
        indirect_out && wr_hit);

endmodule
`default_nettype wire

/* verification/status_page_pwm_regs_test.sv */
// Self-checking bench for the status, page and first-PWM register slice
`timescale 1ns/1ps
`default_nettype none
`include "spp_cfg.svh"
`define CHK(g, e) chk(16'(g), 16'(e))

module status_page_pwm_regs_test;
    import spp_pkg::*;

    logic          mclk;
    logic          resetn;
    spp_cpu_req_t  req;
    logic          sleep_i;
    logic          wdog_clr;
    logic          expire_i;
    logic          pcload_i;
    logic          adc_done;
    logic [9:0]    adc_val;
    logic          wave2;
    spp_pin_drv_t  cin1;
    spp_pin_drv_t  cin2;
    spp_pin_in_t   pins;
    logic [7:0]    rdata;
    logic [5:0]    eff_addr;
    logic          indirect;
    logic [1:0]    bank;
    logic [1:0]    rpage;
    logic          cpage;
    logic [1:0]    prog_page;
    logic [1:0]    pc_high;
    logic [7:0]    adc_low;
    logic [9:0]    cnt1;
    logic [9:0]    cnt2;
    logic          wave1;
    spp_pin_drv_t  pin1;
    spp_pin_drv_t  pin2;
    logic [5:0]    port6;
    logic [7:0]    port7;
    logic [1:0]    gpio6;
    logic          gpio7_0;
    logic [9:0]    held;
    int            failures;
    int            total_checks;
    int            divs [4] = '{2, 8, 32, 64};

    spp_regs DUT (
        .mclk_in                 (mclk),
        .resetn_in               (resetn),
        .cpu_req_in              (req),
        .reg_rdata_out           (rdata),
        .eff_addr_out            (eff_addr),
        .indirect_out            (indirect),
        .ram_bank_out            (bank),
        .reg_page_out            (rpage),
        .ctrl_page_out           (cpage),
        .sleep_instr_in          (sleep_i),
        .watchdog_clear_instr_in (wdog_clr),
        .wdt_expire_in           (expire_i),
        .pc_page_load_in         (pcload_i),
        .prog_page_out           (prog_page),
        .pc_high_out             (pc_high),
        .adc_done_in             (adc_done),
        .adc_result_in           (adc_val),
        .adc_low_out             (adc_low),
        .pwm_two_wave_in         (wave2),
        .first_counter_out       (cnt1),
        .second_counter_out      (cnt2),
        .pwm_one_wave_out        (wave1),
        .port_c_one_in           (cin1),
        .port_c_two_in           (cin2),
        .port_c_pin_one_out      (pin1),
        .port_c_pin_two_out      (pin2),
        .pins_in                 (pins),
        .port6_data_out          (port6),
        .port7_data_out          (port7),
        .port6_gpio_out          (gpio6),
        .p70_gpio_out            (gpio7_0)
    );

    always #50 mclk = ~mclk;

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
        end
    endtask

    task automatic wreg(input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk);
        req = '{addr: a, wr: 1'b1, wdata: d};
        @(negedge mclk);
        req.wr = 1'b0;
    endtask

    // Read data trails the address by one edge
    task automatic rchk(input logic [5:0] a, input logic [7:0] e);
        @(negedge mclk);
        req.addr = a;
        @(negedge mclk);
        `CHK(rdata, e);
    endtask

    task automatic pulse(input int k);
        @(negedge mclk);
        case (k)
            0: sleep_i = 1'b1;
            1: wdog_clr = 1'b1;
            2: expire_i = 1'b1;
            3: pcload_i = 1'b1;
            default: adc_done = 1'b1;
        endcase
        @(negedge mclk);
        {sleep_i, wdog_clr, expire_i, pcload_i, adc_done} = 5'h00;
    endtask

    // Cycles between two counter steps; first step only aligns
    task automatic meas(input bit two, input int e);
        logic [9:0] v;
        int         n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            v = two ? cnt2 : cnt1;
            while ((two ? cnt2 : cnt1) === v && n < 200) begin
                @(negedge mclk);
                n++;
            end
        end
        `CHK(n, e);
    endtask

    task automatic waitc(input logic [9:0] v);
        int n;
        n = 0;
        while (cnt1 !== v && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        `CHK(cnt1, v);
    endtask

    task automatic complete_run;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Whole sequence needs well under 10000 cycles
    initial begin
        #(100 * 20000);
        failures++;
        complete_run();
    end

    initial begin
        mclk = 1'b0;
        resetn = 1'b0;
        req = '0;
        {sleep_i, wdog_clr, expire_i, pcload_i, adc_done} = 5'h00;
        adc_val = 10'h000;
        wave2 = 1'b0;
        cin1 = '{data: 1'b1, oe_n: 1'b1};
        cin2 = cin1;
        pins = '0;
        failures = 0;
        total_checks = 0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        resetn = 1'b1;
        rchk(6'h03, 8'h18);
        rchk(6'h04, 8'h00);
        rchk(6'h05, 8'h00);
        wreg(6'h03, 8'hFF);
        `CHK({rpage, cpage}, 3'h7);
        rchk(6'h03, 8'hFF);
        rchk(6'h05, 8'h00);
        rchk(6'h06, 8'h00);
        rchk(6'h07, 8'h00);
        wreg(6'h03, 8'h40);
        `CHK({rpage, cpage}, 3'h2);
        rchk(6'h03, 8'h58);
        pulse(0);
        rchk(6'h03, 8'h50);
        pulse(2);
        rchk(6'h03, 8'h40);
        pulse(1);
        rchk(6'h03, 8'h58);
        pulse(2);
        rchk(6'h03, 8'h48);
        wreg(6'h07, 8'hFF);
        rchk(6'h07, 8'h04);
        adc_val = 10'h2A5;
        pulse(4);
        `CHK(adc_low, 8'hA5);
        rchk(6'h07, 8'h24);
        wreg(6'h07, 8'h00);
        pulse(4);
        `CHK(adc_low, 8'hA9);
        rchk(6'h07, 8'h00);
        wreg(6'h04, 8'hC5);
        `CHK(bank, 2'h3);
        req.addr = 6'h00;
        #1;
        `CHK({indirect, eff_addr}, 7'h45);
        wreg(6'h03, 8'h00);
        wreg(6'h05, 8'h03);
        `CHK(prog_page, 2'h3);
        pulse(3);
        `CHK(pc_high, 2'h3);
        wreg(6'h06, 8'hFF);
        `CHK(port6, 6'h3F);
        rchk(6'h06, 8'h3F);
        pins = '{p71_pin: 1'b1, crystal_mode: 1'b0, reset_pin_option: 1'b0,
                 pll_cap_pin_option: 1'b0};
        wreg(6'h07, 8'hFF);
        `CHK(port7, 8'h79);
        rchk(6'h07, 8'h7B);
        wreg(6'h07, 8'h00);
        rchk(6'h07, 8'h02);
        `CHK({gpio6, gpio7_0}, 3'h7);
        pins.crystal_mode = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK({gpio6, gpio7_0}, 3'h0);
        // Reset option hides the pin; capacitor option frees bit 0
        pins.reset_pin_option = 1'b1;
        pins.pll_cap_pin_option = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK({gpio6, gpio7_0}, 3'h1);
        rchk(6'h07, 8'h00);
        wreg(6'h03, 8'hC0);
        wreg(6'h06, 8'h03);
        wreg(6'h07, 8'hFF);
        rchk(6'h07, 8'h03);
        rchk(6'h06, 8'h03);
        `CHK(pin1, cin1);
        for (int c = 0; c < 4; c++) begin
            wreg(6'h05, 8'h10 | 8'(c));
            meas(1'b0, divs[c]);
        end
        `CHK(cnt2, 10'h000);
        wreg(6'h05, 8'h24);
        held = cnt1;
        meas(1'b1, 8);
        `CHK(cnt1, held);
        wave2 = 1'b1;
        wreg(6'h05, 8'hA4);
        `CHK(pin2, 2'h2);
        wreg(6'h05, 8'h50);
        `CHK(pin2, cin2);
        `CHK(pin1.oe_n, 1'b0);
        // Duty is 0x303: high after wrap, low once the count reaches it
        waitc(10'h001);
        `CHK({wave1, pin1.data}, 2'h3);
        waitc(10'h302);
        `CHK({wave1, pin1.data}, 2'h3);
        waitc(10'h303);
        `CHK({wave1, pin1.data}, 2'h0);
        complete_run();
    end
endmodule

`default_nettype wire
